/* File: core/i2cssf_defs.svh */
// Register address, field positions and reset values of the slave status block
`ifndef I2CSSF_DEFS_SVH
`define I2CSSF_DEFS_SVH
`define I2CSSF_STATUS_ADDR 8'hEC
`define I2CSSF_STATUS_RESET 8'h00
`define I2CSSF_HOLD_RESET 4'h0
`define I2CSSF_BIT_FIRST 7
`define I2CSSF_BIT_ADDR 6
`define I2CSSF_BIT_STOP 5
`define I2CSSF_BIT_RPST 4
`define I2CSSF_BIT_TXB 3
`define I2CSSF_BIT_RCB 2
`define I2CSSF_BIT_SADR 1
`define I2CSSF_BIT_NACK 0
`endif

/* File: core/i2cssf_pkg.sv */
// Types shared by the slave status block
package i2cssf_pkg;
    // Events raised by the link-side engine, one pulse each
    typedef struct packed {
        logic addr_match;
        logic addr_second;
        logic stop_seen;
        logic rpt_start;
        logic tx_ready;
        logic rx_byte;
        logic nack;
        logic ack;
    } i2cssf_evt_t;
    // CPU-side special-function access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } i2cssf_sfr_t;
endpackage : i2cssf_pkg

/* File: core/i2cssf_status.sv */
// Status and flag logic of the I2C slave controller
// Overview of operation
// [RQ1] First-byte indicator sets when the held byte is first after an address match
// [RQ2] First-byte indicator clears once software reads that first byte
// [RQ3] Address-match flag sets on primary or secondary address match; software clears it
// [RQ4] Address-match flag with its enable raises the slave interrupt
// [RQ5] Stop flag sets on STOP condition; software clears it
// [RQ6] Repeated-start flag sets on repeated START; software clears it
// [RQ7] Status register at 0xEC, reset 0x00, fixed read order, write flags and hold time
// [RQ8] Transmit-buffer flag sets when ready; clears when software writes data
// [RQ9] Receive-buffer flag sets on new received byte; clears on data read
// [RQ10] Second-address bit tells which address matched; clears with address-match flag
// [RQ11] NACK bit sets on master NACK; old byte is resent until acknowledged
// [RQ12] Interrupt stays high while any enabled flag remains set
`include "i2cssf_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module i2cssf_status
    import i2cssf_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic        link_clk_i,
    input  wire i2cssf_evt_t link_evt_i,
    input  wire i2cssf_sfr_t sfr_i,
    input  wire logic        data_rd_i,
    input  wire logic        data_wr_i,
    input  wire logic [4:0]  irq_en_i,
    output logic      [7:0]  status_o,
    output logic      [3:0]  hold_time_o,
    output logic             resend_old_o,
    output logic             irq_o
);
    localparam int NEV = 8;

    // Reset reaches the link domain through two flip-flops of its own clock;
    // one link edge sampling it is enough; the toggles are cleared on the third link edge
    logic link_rst_s1;
    logic link_rst_s2;
    always_ff @(posedge link_clk_i)
    begin
        link_rst_s1 <= reset_i;
        link_rst_s2 <= link_rst_s1;
    end

    // A match and its address choice fold into two one-bit events, so no
    // multi-bit word crosses; exactly one of the two fires per match
    logic [NEV-1:0] link_bits;
    assign link_bits = {link_evt_i.addr_match & ~link_evt_i.addr_second, // Primary
                        link_evt_i.addr_match & link_evt_i.addr_second,  // Secondary
                        link_evt_i.stop_seen,
                        link_evt_i.rpt_start,
                        link_evt_i.tx_ready,
                        link_evt_i.rx_byte,
                        link_evt_i.nack,
                        link_evt_i.ack};

    // Link side: each event flips a toggle, safe across unrelated clocks
    logic [NEV-1:0] link_tog;
    always_ff @(posedge link_clk_i)
    begin
        if (link_rst_s2)
            link_tog <= '0;
        else
            link_tog <= link_tog ^ link_bits;
    end

    // Two flip-flop synchronisers plus an edge register per event; the third
    // flop only exists to find the toggle's edge and reads nothing but the second
    logic [NEV-1:0] sync1;
    logic [NEV-1:0] sync2;
    logic [NEV-1:0] sync3;
    logic [NEV-1:0] evt_pulse;
    genvar g;
    generate
        for (g = 0; g < NEV; g++)
        begin : g_sync
            always_ff @(posedge mclk_i)
            begin
                if (reset_i)
                begin
                    sync1[g] <= 1'b0;
                    sync2[g] <= 1'b0;
                    sync3[g] <= 1'b0;
                end
                else
                begin
                    sync1[g] <= link_tog[g];
                    sync2[g] <= sync1[g];
                    sync3[g] <= sync2[g];
                end
            end
            assign evt_pulse[g] = sync2[g] ^ sync3[g];
        end
    endgenerate

    // Bit 7 pulses for a primary match, bit 6 for a secondary one; either of
    // them is a match, and bit 6 alone tells which address it was
    i2cssf_evt_t ev;
    wire match_pri = evt_pulse[7];
    wire match_sec = evt_pulse[6];
    assign ev = {match_pri | match_sec, match_sec, evt_pulse[5:0]};

    // Register decode
    wire st_wr = sfr_i.wr && (sfr_i.addr == `I2CSSF_STATUS_ADDR);
    wire [7:0] wd = sfr_i.wdata;

    // Write clears a condition flag with a 0; set still wins over that clear.
    // Bit 7 and the NACK bit cannot be written; bits 3..0 feed the hold field
    logic f_first, f_addr, f_stop, f_rpst, f_txb, f_rcb, f_sadr, f_nack;
    logic [3:0] hold;
    wire clr_addr = st_wr && !wd[`I2CSSF_BIT_ADDR];
    wire clr_stop = st_wr && !wd[`I2CSSF_BIT_STOP];
    wire clr_rpst = st_wr && !wd[`I2CSSF_BIT_RPST];
    wire next_addr = ev.addr_match | (f_addr & ~clr_addr); // RQ3
    wire next_stop = ev.stop_seen | (f_stop & ~clr_stop); // RQ5
    wire next_rpst = ev.rpt_start | (f_rpst & ~clr_rpst); // RQ6

    // First received byte after a match; cleared by reading it
    logic await_first;
    wire next_await = ev.addr_match | (await_first & ~ev.rx_byte);
    wire next_first = (ev.rx_byte & await_first) | (f_first & ~data_rd_i); // RQ1 RQ2
    wire next_txb = ev.tx_ready | (f_txb & ~data_wr_i); // RQ8
    wire next_rcb = ev.rx_byte | (f_rcb & ~data_rd_i); // RQ9
    wire next_sadr = ev.addr_match ? ev.addr_second : (f_sadr & ~clr_addr); // RQ10
    wire next_nack = ev.nack | (f_nack & ~ev.ack); // RQ11
    wire [7:0] next_status = {next_first, next_addr, next_stop, next_rpst,
                              next_txb, next_rcb, next_sadr, next_nack};
    wire [4:0] flags_en = {next_addr, next_stop, next_rpst, next_txb, next_rcb} & irq_en_i;

    // Flag storage
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            {f_first, f_addr, f_stop, f_rpst, f_txb, f_rcb, f_sadr, f_nack} <= `I2CSSF_STATUS_RESET;
            await_first <= 1'b0;
            hold        <= `I2CSSF_HOLD_RESET;
        end
        else
        begin
            {f_first, f_addr, f_stop, f_rpst, f_txb, f_rcb, f_sadr, f_nack} <= next_status;
            await_first <= next_await;
            if (st_wr)
                hold <= wd[3:0]; // RQ7
        end
    end

    // Registered outputs mirror the next flag state, so the read value and the
    // interrupt line change on the same edge and never disagree
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            status_o     <= `I2CSSF_STATUS_RESET;
            hold_time_o  <= `I2CSSF_HOLD_RESET;
            resend_old_o <= 1'b0;
            irq_o        <= 1'b0;
        end
        else
        begin
            status_o     <= next_status; // RQ7
            hold_time_o  <= st_wr ? wd[3:0] : hold;
            resend_old_o <= next_nack; // RQ11
            irq_o        <= |flags_en; // RQ4 RQ12
        end
    end

    // Checks on the condition flags: software clear, holding, and an event
    // that lands in the same cycle as a clearing write still sets the flag
    a_addr_clear: assert property (@(posedge mclk_i) disable iff (reset_i) // RQ3
        f_addr && clr_addr && !ev.addr_match |=> !f_addr) else $error("addr flag not cleared");
    a_addr_set: assert property (@(posedge mclk_i) disable iff (reset_i) // RQ3
        ev.addr_match |=> f_addr && status_o[`I2CSSF_BIT_ADDR]) else $error("addr not set");
    a_stop_set: assert property (@(posedge mclk_i) disable iff (reset_i) // RQ5
        ev.stop_seen |=> f_stop) else $error("stop flag not set");
    a_stop_hold: assert property (@(posedge mclk_i) disable iff (reset_i) // RQ5
        f_stop && !st_wr |=> f_stop) else $error("stop flag lost");
    a_rpst_set: assert property (@(posedge mclk_i) disable iff (reset_i) // RQ6
        ev.rpt_start |=> f_rpst && status_o[`I2CSSF_BIT_RPST]) else $error("rpst not set");
    a_rpst_hold: assert property (@(posedge mclk_i) disable iff (reset_i) // RQ6
        f_rpst && !st_wr |=> f_rpst) else $error("rpst flag lost");

    // Checks on the byte flags and the first-byte indicator
    a_txb_set: assert property (@(posedge mclk_i) disable iff (reset_i) // RQ8
        ev.tx_ready |=> f_txb) else $error("txb not set");
    a_txb_clear: assert property (@(posedge mclk_i) disable iff (reset_i) // RQ8
        data_wr_i && !ev.tx_ready |=> !f_txb) else $error("txb not cleared");
    a_rcb_set: assert property (@(posedge mclk_i) disable iff (reset_i) // RQ9
        ev.rx_byte |=> f_rcb) else $error("rcb not set");
    a_rcb_clear: assert property (@(posedge mclk_i) disable iff (reset_i) // RQ9
        data_rd_i && !ev.rx_byte |=> !f_rcb) else $error("rcb not cleared");
    a_first_set: assert property (@(posedge mclk_i) disable iff (reset_i) // RQ1
        ev.rx_byte && await_first |=> f_first) else $error("first not set");
    a_first_read: assert property (@(posedge mclk_i) disable iff (reset_i) // RQ2
        f_first && data_rd_i && !ev.rx_byte |=> !f_first) else $error("first not cleared");

    // Checks on the address choice, the NACK bit and the hold-time field; the
    // hold output must show a written value on the very next edge
    a_sadr_clear: assert property (@(posedge mclk_i) disable iff (reset_i) // RQ10
        !f_addr |-> !f_sadr) else $error("sadr without match");
    a_sadr_follow: assert property (@(posedge mclk_i) disable iff (reset_i) // RQ10
        ev.addr_match |=> f_sadr == $past(ev.addr_second)) else $error("sadr wrong");
    a_nack_resend: assert property (@(posedge mclk_i) disable iff (reset_i) // RQ11
        ev.nack |=> resend_old_o) else $error("no resend");
    a_nack_clear: assert property (@(posedge mclk_i) disable iff (reset_i) // RQ11
        ev.ack && !ev.nack |=> !resend_old_o) else $error("resend after ack");
    a_hold_write: assert property (@(posedge mclk_i) disable iff (reset_i) // RQ7
        st_wr |=> hold_time_o == $past(wd[3:0])) else $error("hold not written");

    // Checks on the interrupt line
    a_addr_irq: assert property (@(posedge mclk_i) disable iff (reset_i) // RQ4
        next_addr && irq_en_i[4] |=> irq_o) else $error("addr irq missing");
    a_irq_hold: assert property (@(posedge mclk_i) disable iff (reset_i) // RQ12
        next_stop && irq_en_i[3] |=> irq_o) else $error("stop irq missing");
    a_irq_quiet: assert property (@(posedge mclk_i) disable iff (reset_i) // RQ12
        !next_addr && !next_stop && !next_rpst && !next_txb && !next_rcb |=> !irq_o)
        else $error("irq without flag");

    // Scenarios worth seeing: a match then a byte, a secondary match, a stop, a NACK retry, a status read
    c_match: cover property (@(posedge mclk_i) ev.addr_match ##[1:50] ev.rx_byte);
    c_second: cover property (@(posedge mclk_i) ev.addr_match && ev.addr_second);
    c_stop: cover property (@(posedge mclk_i) ev.stop_seen);
    c_nack: cover property (@(posedge mclk_i) ev.nack ##[1:50] ev.ack);
    c_status_read: cover property (@(posedge mclk_i) sfr_i.rd && sfr_i.addr == `I2CSSF_STATUS_ADDR);
endmodule : i2cssf_status
`default_nettype wire

/* File: bench/i2cssf_link_model.sv */
// Partner model: link-side engine raising one-cycle event pulses
`timescale 1ns/1ps
`default_nettype none
module i2cssf_link_model
    import i2cssf_pkg::*;
(
    input  wire logic        link_clk_i,
    input  wire i2cssf_evt_t req_i,
    input  wire logic        tgl_i,
    output var  i2cssf_evt_t evt_o
);
    logic seen = 1'b0;
    // A toggle crosses safely from the bench clock; each change gives one pulse
    always @(posedge link_clk_i)
    begin
        seen  <= tgl_i;
        evt_o <= (tgl_i != seen) ? req_i : '0;
    end
endmodule : i2cssf_link_model
`default_nettype wire

/* File: bench/i2c_slave_status_flags_tb_top.sv */
// Self-checking bench of the slave status and flag logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module i2c_slave_status_flags_tb_top
    import i2cssf_pkg::*;
;
    logic mclk = 0, link_clk = 0, reset = 1, tgl = 0, rd = 0, wr = 0, sec, resend, irq;
    logic [7:0]  status, exp, d;
    logic [3:0]  hold;
    logic [4:0]  irq_en = 5'h00;
    i2cssf_evt_t req = '0, evt;
    i2cssf_sfr_t sfr = '0;
    int          n_fail = 0, num_checks = 0, seed = 32'h3CFE;
    // Clocks of unrelated phase
    initial forever #4 mclk = ~mclk;
    initial begin #3.3; forever #7.5 link_clk = ~link_clk; end
    i2cssf_link_model u_link (.link_clk_i(link_clk), .req_i(req), .tgl_i(tgl), .evt_o(evt));
    i2cssf_status u_dut (.mclk_i(mclk), .reset_i(reset), .link_clk_i(link_clk),
        .link_evt_i(evt), .sfr_i(sfr), .data_rd_i(rd), .data_wr_i(wr), .irq_en_i(irq_en),
        .status_o(status), .hold_time_o(hold), .resend_old_o(resend), .irq_o(irq));
    task tick(input int n); repeat (n) @(posedge mclk); #1; endtask : tick
    // Wait covers the 5-6 cycle crossing latency with margin
    task send(input logic [7:0] e); req = e; tgl = ~tgl; tick(8); endtask : send
    task pulse(input logic r); rd = r; wr = ~r; tick(1); rd = 0; wr = 0; tick(2); endtask : pulse
    // One status-register access: a write when w is high, otherwise a read
    task sfr_access(input logic w, input logic [7:0] v);
        sfr = '{w, ~w, 8'hEC, v};
        tick(1);
        sfr.wr = 1'b0;
        sfr.rd = 1'b0;
        tick(1);
    endtask : sfr_access
    // Zero in bits 6..4 clears a flag; the second-address bit follows the match flag
    function automatic logic [7:0] after_write(input logic [7:0] s, input logic [7:0] v);
        after_write = s & {1'b1, v[6:4], 4'hF};
        if (!v[6]) after_write[1] = 1'b0;
    endfunction : after_write
    task give_verdict;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    // Hang guard
    initial begin #200000; n_fail++; give_verdict; end
    initial
    begin
        tick(8);
        reset = 0;
        `CHK("reset status", 8'h00, status)
        `CHK("reset hold", 4'h0, hold)
        `CHK("reset irq", 1'b0, irq)
        // The link side leaves reset a few link cycles later; wait before events
        tick(8);
        exp = 8'h00;
        repeat (6)
        begin
            irq_en = 5'($random(seed));
            sec = 1'($random(seed));
            send({1'b1, sec, 6'h00});
            exp[6] = 1'b1;
            exp[1] = sec;
            `CHK("match", exp, status)
            send(8'h20);
            send(8'h10);
            send(8'h04);
            exp[7:2] = exp[7:2] | 6'b101101;
            `CHK("flags", exp, status)
            pulse(1'b1);
            exp[7] = 1'b0;
            exp[2] = 1'b0;
            `CHK("read", exp, status)
            send(8'h04);
            exp[2] = 1'b1;
            `CHK("later byte", exp, status)
            pulse(1'b1);
            send(8'h08);
            send(8'h02);
            exp[3] = 1'b1;
            exp[2] = 1'b0;
            exp[0] = 1'b1;
            `CHK("nack", exp, status)
            `CHK("resend", 1'b1, resend)
            `CHK("irq", |(irq_en & exp[6:2]), irq)
            pulse(1'b0);
            send(8'h01);
            exp[3] = 1'b0;
            exp[0] = 1'b0;
            `CHK("ack", exp, status)
            `CHK("resend clear", 1'b0, resend)
            d = 8'($random(seed));
            sfr_access(1'b1, d);
            exp = after_write(exp, d);
            `CHK("write", exp, status)
            `CHK("hold", d[3:0], hold)
            `CHK("irq", |(irq_en & exp[6:2]), irq)
        end
        // Corner cases: a read changes nothing, ones leave flags, zeros clear them
        sfr_access(1'b0, 8'h00);
        `CHK("status read", exp, status)
        sfr_access(1'b1, 8'hFA);
        exp = after_write(exp, 8'hFA);
        `CHK("write ones", exp, status)
        `CHK("hold ones", 4'hA, hold)
        sfr_access(1'b1, 8'h05);
        exp = after_write(exp, 8'h05);
        `CHK("walk write", exp, status)
        `CHK("walk hold", 4'h5, hold)
        send(8'h24);
        exp[5] = 1'b1;
        exp[2] = 1'b1;
        `CHK("stop rcb", exp, status)
        // Reset again in mid-run; every output must return to zero
        reset = 1'b1;
        tick(8);
        reset = 1'b0;
        `CHK("rerun status", 8'h00, status)
        `CHK("rerun hold", 4'h0, hold)
        `CHK("rerun irq", 1'b0, irq)
        `CHK("rerun resend", 1'b0, resend)
        give_verdict;
    end
endmodule : i2c_slave_status_flags_tb_top
`default_nettype wire
